/* wdcb_top.sv */
/*
 * Watchdog configuration bank: six 8-bit registers behind the serial
 * register port, with the timing, step and error-reaction settings that
 * the window, question and heartbeat logic use.
 * Assumes the serial interface, the lock bit and the watchdog state
 * machines all run on clock_i, so none of their signals is synchronised.
 */
// Functional notes
// - The closed window lasts code times 1,6 ms, taken from bits 7 to 2, up to 100,8 ms.
// - A closed window code of zero leaves the open and closed window times as they were.
// - The open window lasts 3,2, 6,4, 9,6 or 12,8 ms for codes 0 to 3 of bits 1 to 0.
// - A correct window service lowers the window error counter by bits 7 to 4 plus one.
// - A window watchdog error raises the window error counter by bits 3 to 0 plus one.
// - The question pass counter goes down by bits 7 to 4 plus one.
// - The question pass counter goes up by bits 3 to 0 plus one.
// - The total error counter goes down by bits 7 to 4 plus one.
// - The total error counter goes up by bits 3 to 0 plus one.
// - The heartbeat period is bits 6 to 0 times 1,6 ms, and code zero keeps the old period.
// - While the lock bit is one, writes to the error reaction register are ignored.
// - With bit 4 set the current question is kept after a window watchdog error.
// - Bit 3 selects a question sequence period of 16 when zero or 256 when one.
// - A watchdog error asks for a reset only while bit 2 is one.
// - During a watchdog error LIN is forced to receive only when bit 1 is zero.
// - During a watchdog error CAN is forced to receive only when bit 0 is zero.
`timescale 1ns/1ps
`default_nettype none

module wdcb_top #(
    parameter int STEP_CYCLES = wdcb_pkg::TIME_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    // Watchdog status in
    input wire logic config_lock_i,
    input wire logic window_start_i,
    input wire logic period_start_i,
    input wire logic watchdog_error_i,
    input wire logic window_error_i,
    // Communication modes in
    input wire logic lin_rx_only_cfg_i,
    input wire logic can_rx_only_cfg_i,
    // Window settings out
    output logic [wdcb_pkg::TIME_CYCLES_W-1:0] closed_window_cycles_o,
    output logic [wdcb_pkg::TIME_CYCLES_W-1:0] open_window_cycles_o,
    output logic [wdcb_pkg::STEP_W-1:0] window_err_count_down_step_o,
    output logic [wdcb_pkg::STEP_W-1:0] window_err_count_up_step_o,
    // Question and total counter settings out
    output logic [wdcb_pkg::STEP_W-1:0] question_pass_down_step_o,
    output logic [wdcb_pkg::STEP_W-1:0] question_pass_up_step_o,
    output logic [wdcb_pkg::STEP_W-1:0] total_err_down_step_o,
    output logic [wdcb_pkg::STEP_W-1:0] total_err_up_step_o,
    output logic [8:0] question_period_o,
    output logic keep_question_o,
    // Heartbeat out
    output logic [wdcb_pkg::TIME_CYCLES_W-1:0] heartbeat_period_cycles_o,
    // Error reaction out
    output logic reset_request_o,
    output logic lin_rx_only_o,
    output logic can_rx_only_o
);

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic reg_select(input logic [7:0] addr, input logic [7:0] offset);
        reg_select = (addr == offset);
    endfunction

    logic sel_window_timing;
    logic sel_window_steps;
    logic sel_question_steps;
    logic sel_total_steps;
    logic sel_heartbeat;
    logic sel_reaction;
    logic addr_hit;

    assign sel_window_timing = reg_select(reg_addr_i, wdcb_pkg::WINDOW_TIMING_CONFIG_OFF);
    assign sel_window_steps = reg_select(reg_addr_i, wdcb_pkg::WINDOW_ERROR_COUNTER_STEPS_OFF);
    assign sel_question_steps = reg_select(reg_addr_i, wdcb_pkg::QUESTION_PASS_COUNTER_STEPS_OFF);
    assign sel_total_steps = reg_select(reg_addr_i, wdcb_pkg::TOTAL_ERROR_COUNTER_STEPS_OFF);
    assign sel_heartbeat = reg_select(reg_addr_i, wdcb_pkg::HEARTBEAT_PERIOD_CONFIG_OFF);
    assign sel_reaction = reg_select(reg_addr_i, wdcb_pkg::WATCHDOG_ERROR_REACTION_CONFIG_OFF);
    assign addr_hit = sel_window_timing | sel_window_steps | sel_question_steps
                    | sel_total_steps | sel_heartbeat | sel_reaction;

    // Handshake output, combinational by design
    assign reg_hit_o = addr_hit & (reg_wr_i | reg_rd_i);

    // ************************************************************
    // Software registers
    // ************************************************************
    logic [7:0] window_timing_config;
    logic [7:0] window_error_counter_steps;
    logic [7:0] question_pass_counter_steps;
    logic [7:0] total_error_counter_steps;
    logic [7:0] heartbeat_period_config;
    logic [7:0] watchdog_error_reaction_config;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            window_timing_config <= wdcb_pkg::WINDOW_TIMING_CONFIG_RST;
        end else if (reg_wr_i && sel_window_timing) begin
            window_timing_config <= reg_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            window_error_counter_steps <= wdcb_pkg::WINDOW_ERROR_COUNTER_STEPS_RST;
            question_pass_counter_steps <= wdcb_pkg::QUESTION_PASS_COUNTER_STEPS_RST;
            total_error_counter_steps <= wdcb_pkg::TOTAL_ERROR_COUNTER_STEPS_RST;
        end else if (reg_wr_i) begin
            if (sel_window_steps) begin
                window_error_counter_steps <= reg_wdata_i;
            end
            if (sel_question_steps) begin
                question_pass_counter_steps <= reg_wdata_i;
            end
            if (sel_total_steps) begin
                total_error_counter_steps <= reg_wdata_i;
            end
        end
    end

    // Bit 7 is reserved and always reads zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            heartbeat_period_config <= wdcb_pkg::HEARTBEAT_PERIOD_CONFIG_RST;
        end else if (reg_wr_i && sel_heartbeat) begin
            heartbeat_period_config <= reg_wdata_i & wdcb_pkg::HEARTBEAT_PERIOD_CONFIG_MASK;
        end
    end

    // Bits 7 to 5 are reserved and read zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            watchdog_error_reaction_config <= wdcb_pkg::WATCHDOG_ERROR_REACTION_CONFIG_RST;
        end else if (reg_wr_i && sel_reaction && !config_lock_i) begin
            watchdog_error_reaction_config <= reg_wdata_i & wdcb_pkg::WATCHDOG_ERROR_REACTION_CONFIG_MASK;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (sel_window_timing) begin
            next_rdata = window_timing_config;
        end else if (sel_window_steps) begin
            next_rdata = window_error_counter_steps;
        end else if (sel_question_steps) begin
            next_rdata = question_pass_counter_steps;
        end else if (sel_total_steps) begin
            next_rdata = total_error_counter_steps;
        end else if (sel_heartbeat) begin
            next_rdata = heartbeat_period_config;
        end else if (sel_reaction) begin
            next_rdata = watchdog_error_reaction_config;
        end
    end

    // Unmapped addresses answer with zero so software never sees stale data
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ************************************************************
    // Pending window timing
    // ************************************************************
    // A zero closed code is stored and read back, but the timing in use is kept
    logic [wdcb_pkg::CLOSED_WINDOW_TIME_W-1:0] pending_closed_code;
    logic [wdcb_pkg::OPEN_WINDOW_TIME_W-1:0] pending_open_code;
    logic [wdcb_pkg::CLOSED_WINDOW_TIME_W-1:0] written_closed_code;

    assign written_closed_code = reg_wdata_i[wdcb_pkg::CLOSED_WINDOW_TIME_LSB +: wdcb_pkg::CLOSED_WINDOW_TIME_W];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pending_closed_code <= wdcb_pkg::WINDOW_TIMING_CONFIG_RST[wdcb_pkg::CLOSED_WINDOW_TIME_LSB +:
                                                                    wdcb_pkg::CLOSED_WINDOW_TIME_W];
            pending_open_code <= wdcb_pkg::WINDOW_TIMING_CONFIG_RST[wdcb_pkg::OPEN_WINDOW_TIME_LSB +:
                                                                  wdcb_pkg::OPEN_WINDOW_TIME_W];
        end else if (reg_wr_i && sel_window_timing && written_closed_code != '0) begin
            pending_closed_code <= written_closed_code;
            pending_open_code <= reg_wdata_i[wdcb_pkg::OPEN_WINDOW_TIME_LSB +: wdcb_pkg::OPEN_WINDOW_TIME_W];
        end
    end

    // ************************************************************
    // Pending heartbeat period
    // ************************************************************
    logic [wdcb_pkg::HEARTBEAT_PERIOD_W-1:0] pending_heartbeat_code;
    logic [wdcb_pkg::HEARTBEAT_PERIOD_W-1:0] written_heartbeat_code;

    assign written_heartbeat_code = reg_wdata_i[wdcb_pkg::HEARTBEAT_PERIOD_LSB +: wdcb_pkg::HEARTBEAT_PERIOD_W];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pending_heartbeat_code <= wdcb_pkg::HEARTBEAT_PERIOD_CONFIG_RST[wdcb_pkg::HEARTBEAT_PERIOD_LSB +:
                                                                           wdcb_pkg::HEARTBEAT_PERIOD_W];
        end else if (reg_wr_i && sel_heartbeat && written_heartbeat_code != '0) begin
            pending_heartbeat_code <= written_heartbeat_code;
        end
    end

    // ************************************************************
    // Active settings
    // ************************************************************
    // Settings change only at a start pulse so a running window is never cut short
    logic [wdcb_pkg::CLOSED_WINDOW_TIME_W-1:0] active_closed_code;
    logic [wdcb_pkg::OPEN_WINDOW_TIME_W-1:0] active_open_code;
    logic [wdcb_pkg::HEARTBEAT_PERIOD_W-1:0] active_heartbeat_code;
    logic [7:0] active_window_steps;
    logic [7:0] active_question_steps;
    logic [7:0] active_total_steps;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            active_closed_code <= wdcb_pkg::WINDOW_TIMING_CONFIG_RST[wdcb_pkg::CLOSED_WINDOW_TIME_LSB +:
                                                                   wdcb_pkg::CLOSED_WINDOW_TIME_W];
            active_open_code <= wdcb_pkg::WINDOW_TIMING_CONFIG_RST[wdcb_pkg::OPEN_WINDOW_TIME_LSB +:
                                                                 wdcb_pkg::OPEN_WINDOW_TIME_W];
            active_window_steps <= wdcb_pkg::WINDOW_ERROR_COUNTER_STEPS_RST;
        end else if (window_start_i) begin
            active_closed_code <= pending_closed_code;
            active_open_code <= pending_open_code;
            active_window_steps <= window_error_counter_steps;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            active_heartbeat_code <= wdcb_pkg::HEARTBEAT_PERIOD_CONFIG_RST[wdcb_pkg::HEARTBEAT_PERIOD_LSB +:
                                                                          wdcb_pkg::HEARTBEAT_PERIOD_W];
            active_question_steps <= wdcb_pkg::QUESTION_PASS_COUNTER_STEPS_RST;
            active_total_steps <= wdcb_pkg::TOTAL_ERROR_COUNTER_STEPS_RST;
        end else if (period_start_i) begin
            active_heartbeat_code <= pending_heartbeat_code;
            active_question_steps <= question_pass_counter_steps;
            active_total_steps <= total_error_counter_steps;
        end
    end

    // ************************************************************
    // Step decoding
    // ************************************************************
    // Index 0..5: window down/up, question down/up, total down/up
    logic [wdcb_pkg::STEP_CODE_W-1:0] step_code [6];
    logic [wdcb_pkg::STEP_W-1:0] step_size [6];
    logic [wdcb_pkg::STEP_W-1:0] next_step [6];

    always_comb begin
        step_code[0] = active_window_steps[wdcb_pkg::DOWN_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
        step_code[1] = active_window_steps[wdcb_pkg::UP_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
        step_code[2] = active_question_steps[wdcb_pkg::DOWN_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
        step_code[3] = active_question_steps[wdcb_pkg::UP_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
        step_code[4] = active_total_steps[wdcb_pkg::DOWN_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
        step_code[5] = active_total_steps[wdcb_pkg::UP_STEP_LSB +: wdcb_pkg::STEP_CODE_W];
    end

    for (genvar i = 0; i < 6; i++) begin : g_step
        wdcb_step_decode u_step (
            .code_i(step_code[i]),
            .step_o(step_size[i])
        );
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int j = 0; j < 6; j++) begin
                next_step[j] <= 5'h01;
            end
        end else begin
            for (int j = 0; j < 6; j++) begin
                next_step[j] <= step_size[j];
            end
        end
    end

    assign window_err_count_down_step_o = next_step[0];
    assign window_err_count_up_step_o = next_step[1];
    assign question_pass_down_step_o = next_step[2];
    assign question_pass_up_step_o = next_step[3];
    assign total_err_down_step_o = next_step[4];
    assign total_err_up_step_o = next_step[5];

    // ************************************************************
    // Durations in clock cycles
    // ************************************************************
    localparam logic [wdcb_pkg::TIME_CYCLES_W-1:0] STEP_UNIT = STEP_CYCLES[wdcb_pkg::TIME_CYCLES_W-1:0];
    localparam logic [wdcb_pkg::TIME_CYCLES_W-1:0] OPEN_UNIT =
        wdcb_pkg::TIME_CYCLES_W'(STEP_CYCLES * wdcb_pkg::OPEN_WINDOW_UNIT_STEPS);

    logic [wdcb_pkg::TIME_CYCLES_W-1:0] closed_cycles;
    logic [wdcb_pkg::TIME_CYCLES_W-1:0] open_cycles;
    logic [wdcb_pkg::TIME_CYCLES_W-1:0] heartbeat_cycles;
    logic [6:0] open_multiple;

    assign open_multiple = {5'h00, active_open_code} + 7'h01;

    wdcb_time_scale u_closed_scale (
        .code_i({1'b0, active_closed_code}),
        .unit_i(STEP_UNIT),
        .cycles_o(closed_cycles)
    );

    wdcb_time_scale u_open_scale (
        .code_i(open_multiple),
        .unit_i(OPEN_UNIT),
        .cycles_o(open_cycles)
    );

    wdcb_time_scale u_heartbeat_scale (
        .code_i(active_heartbeat_code),
        .unit_i(STEP_UNIT),
        .cycles_o(heartbeat_cycles)
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            closed_window_cycles_o <= '0;
            open_window_cycles_o <= '0;
            heartbeat_period_cycles_o <= '0;
        end else begin
            closed_window_cycles_o <= closed_cycles;
            open_window_cycles_o <= open_cycles;
            heartbeat_period_cycles_o <= heartbeat_cycles;
        end
    end

    // ************************************************************
    // Question generation and error reaction
    // ************************************************************
    // Reaction bits act at once: a watchdog error must not wait for a window start
    logic keep_question_en;
    logic long_sequence;
    logic reset_en;
    logic lin_keep_mode;
    logic can_keep_mode;

    assign keep_question_en = watchdog_error_reaction_config[wdcb_pkg::KEEP_QUESTION_BIT];
    assign long_sequence = watchdog_error_reaction_config[wdcb_pkg::QUESTION_SEQUENCE_BIT];
    assign reset_en = watchdog_error_reaction_config[wdcb_pkg::ERROR_RESET_ENABLE_BIT];
    assign lin_keep_mode = watchdog_error_reaction_config[wdcb_pkg::LIN_ERROR_MODE_BIT];
    assign can_keep_mode = watchdog_error_reaction_config[wdcb_pkg::CAN_ERROR_MODE_BIT];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            question_period_o <= wdcb_pkg::QUESTION_PERIOD_SHORT;
            keep_question_o <= 1'b0;
        end else begin
            question_period_o <= long_sequence ? wdcb_pkg::QUESTION_PERIOD_LONG
                                               : wdcb_pkg::QUESTION_PERIOD_SHORT;
            keep_question_o <= keep_question_en & window_error_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reset_request_o <= 1'b0;
            lin_rx_only_o <= 1'b0;
            can_rx_only_o <= 1'b0;
        end else begin
            reset_request_o <= watchdog_error_i & reset_en;
            lin_rx_only_o <= (watchdog_error_i && !lin_keep_mode) ? 1'b1 : lin_rx_only_cfg_i;
            can_rx_only_o <= (watchdog_error_i && !can_keep_mode) ? 1'b1 : can_rx_only_cfg_i;
        end
    end

endmodule

`default_nettype wire

/* wdcb_pkg.sv */
/*
 * Shared constants of the watchdog configuration bank: register offsets,
 * reset values, field positions and the time base of the window and
 * heartbeat figures.
 * Assumes a 50 MHz device clock and an 8-bit register address space.
 */
package wdcb_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] WINDOW_TIMING_CONFIG_OFF = 8'h5F;
    localparam logic [7:0] WINDOW_ERROR_COUNTER_STEPS_OFF = 8'h60;
    localparam logic [7:0] QUESTION_PASS_COUNTER_STEPS_OFF = 8'h61;
    localparam logic [7:0] TOTAL_ERROR_COUNTER_STEPS_OFF = 8'h62;
    localparam logic [7:0] HEARTBEAT_PERIOD_CONFIG_OFF = 8'h63;
    localparam logic [7:0] WATCHDOG_ERROR_REACTION_CONFIG_OFF = 8'h64;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] WINDOW_TIMING_CONFIG_RST = 8'hFF;
    localparam logic [7:0] WINDOW_ERROR_COUNTER_STEPS_RST = 8'h77;
    localparam logic [7:0] QUESTION_PASS_COUNTER_STEPS_RST = 8'hF7;
    localparam logic [7:0] TOTAL_ERROR_COUNTER_STEPS_RST = 8'h77;
    localparam logic [7:0] HEARTBEAT_PERIOD_CONFIG_RST = 8'h47;
    localparam logic [7:0] WATCHDOG_ERROR_REACTION_CONFIG_RST = 8'h03;

    // ************************************************************
    // Field positions and masks
    // ************************************************************
    localparam int CLOSED_WINDOW_TIME_LSB = 2;
    localparam int CLOSED_WINDOW_TIME_W = 6;
    localparam int OPEN_WINDOW_TIME_LSB = 0;
    localparam int OPEN_WINDOW_TIME_W = 2;
    localparam int DOWN_STEP_LSB = 4;
    localparam int UP_STEP_LSB = 0;
    localparam int STEP_CODE_W = 4;
    localparam int STEP_W = 5;
    localparam int HEARTBEAT_PERIOD_LSB = 0;
    localparam int HEARTBEAT_PERIOD_W = 7;
    localparam int KEEP_QUESTION_BIT = 4;
    localparam int QUESTION_SEQUENCE_BIT = 3;
    localparam int ERROR_RESET_ENABLE_BIT = 2;
    localparam int LIN_ERROR_MODE_BIT = 1;
    localparam int CAN_ERROR_MODE_BIT = 0;
    localparam logic [7:0] HEARTBEAT_PERIOD_CONFIG_MASK = 8'h7F;
    localparam logic [7:0] WATCHDOG_ERROR_REACTION_CONFIG_MASK = 8'h1F;

    // ************************************************************
    // Time base
    // ************************************************************
    localparam int CLOCK_FREQ_KHZ = 50000;
    localparam int TIME_STEP_US = 1600;
    localparam int OPEN_WINDOW_UNIT_US = 3200;
    localparam int TIME_STEP_CYCLES = TIME_STEP_US * CLOCK_FREQ_KHZ / 1000;
    localparam int OPEN_WINDOW_UNIT_STEPS = OPEN_WINDOW_UNIT_US / TIME_STEP_US;
    localparam int TIME_CYCLES_W = 24;

    // ************************************************************
    // Question sequence periods
    // ************************************************************
    localparam logic [8:0] QUESTION_PERIOD_SHORT = 9'h010;
    localparam logic [8:0] QUESTION_PERIOD_LONG = 9'h100;

endpackage

/* wdcb_step_decode.sv */
/*
 * Turns a four-bit counter step code into the step size, code plus one.
 * Assumes the code comes from a register on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module wdcb_step_decode (
    // Code in
    input wire logic [wdcb_pkg::STEP_CODE_W-1:0] code_i,
    // Step out
    output logic [wdcb_pkg::STEP_W-1:0] step_o
);

    // Widen first so that code 4'hF gives 16 and does not wrap to 0
    assign step_o = {1'b0, code_i} + 5'h01;

endmodule

`default_nettype wire

/* wdcb_time_scale.sv */
/*
 * Scales a duration code by a unit count of clock cycles.
 * Assumes the product of code and unit fits the output width.
 */
`timescale 1ns/1ps
`default_nettype none

module wdcb_time_scale (
    // Operands
    input wire logic [6:0] code_i,
    input wire logic [wdcb_pkg::TIME_CYCLES_W-1:0] unit_i,
    // Product
    output logic [wdcb_pkg::TIME_CYCLES_W-1:0] cycles_o
);

    logic [wdcb_pkg::TIME_CYCLES_W+6:0] product;

    assign product = {{7{1'b0}}, unit_i} * {{wdcb_pkg::TIME_CYCLES_W{1'b0}}, code_i};
    assign cycles_o = product[wdcb_pkg::TIME_CYCLES_W-1:0];

endmodule

`default_nettype wire

/* wdcb_checker.sv */
/* Assertions on the ports of the watchdog configuration bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module wdcb_checker #(parameter int STEP_CYCLES = 10) (
    // Clock, reset and inputs
    input wire logic clock_i, rst_i, reg_rd_i, window_start_i, period_start_i,
    input wire logic watchdog_error_i, window_error_i, lin_rx_only_cfg_i, can_rx_only_cfg_i,
    // Outputs watched
    input wire logic reg_rvalid_o, keep_question_o, reset_request_o, lin_rx_only_o, can_rx_only_o,
    input wire logic [23:0] closed_window_cycles_o, heartbeat_period_cycles_o,
    input wire logic [4:0] window_err_count_up_step_o,
    input wire logic [8:0] question_period_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Outputs settle one edge after a start or a reset, so those edges are skipped
    sequence no_win_s; !$past(rst_i) && !$past(window_start_i) && !window_start_i; endsequence
    sequence no_per_s; !$past(rst_i) && !$past(period_start_i) && !period_start_i; endsequence
    read_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i)) else $error("read answer late");
    reset_gate_a: assert property (!watchdog_error_i |=> !reset_request_o) else $error("stray reset");
    lin_mode_a: assert property (!watchdog_error_i |=> lin_rx_only_o == $past(lin_rx_only_cfg_i))
        else $error("lin mode wrong");
    can_mode_a: assert property (!watchdog_error_i |=> can_rx_only_o == $past(can_rx_only_cfg_i))
        else $error("can mode wrong");
    keep_question_a: assert property (!window_error_i |=> !keep_question_o) else $error("stray keep");
    question_period_a: assert property (question_period_o inside {9'h010, 9'h100})
        else $error("bad question period");
    step_range_a: assert property (no_win_s |=> $stable(window_err_count_up_step_o)
        && window_err_count_up_step_o inside {[5'h01:5'h10]}) else $error("step out of range");
    window_hold_a: assert property (no_win_s |=> $stable(closed_window_cycles_o))
        else $error("window time moved");
    beat_hold_a: assert property (no_per_s |=> $stable(heartbeat_period_cycles_o))
        else $error("heartbeat moved");
endmodule
bind wdcb_top wdcb_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_u (.*);
`default_nettype wire

/* wdcb_host_model.sv */
/* Microcontroller model driving the register port.
   Assumes strobes are taken at the rising edge after they rise. */
`timescale 1ns/1ps
`default_nettype none
module wdcb_host_model (
    // Clock
    input wire logic clock_i,
    // Register port
    output logic wr_o, rd_o,
    output logic [7:0] addr_o, wdata_o
);
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0_0000;
    // One access; released lines show the inverse so stale data is never read back
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge clock_i);
        #1 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(posedge clock_i);
        #1 {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
/* Self-checking bench of the watchdog configuration bank.
   Assumes the checker binds itself; step count shortened to 10 cycles. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench;
    logic clock_i = 0, rst_i = 1, config_lock_i = 0, window_start_i = 0, period_start_i = 0, hit_seen = 0;
    logic watchdog_error_i = 0, window_error_i = 0, lin_rx_only_cfg_i = 1, can_rx_only_cfg_i = 1;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, reg_hit_o, keep_question_o, reset_request_o, lin_rx_only_o, can_rx_only_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [23:0] closed_window_cycles_o, open_window_cycles_o, heartbeat_period_cycles_o;
    logic [4:0] window_err_count_down_step_o, window_err_count_up_step_o, question_pass_down_step_o;
    logic [4:0] question_pass_up_step_o, total_err_down_step_o, total_err_up_step_o;
    logic [8:0] question_period_o;
    logic [7:0] rv [6] = '{8'hff, 8'h77, 8'hf7, 8'h77, 8'h47, 8'h03};
    int n_errors = 0, n_compared = 0;
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) if (reg_rd_i) hit_seen <= reg_hit_o;
    wdcb_top #(.STEP_CYCLES(10)) dut_u (.*);
    wdcb_host_model host_u (.clock_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    task cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task wr(input logic [7:0] a, d);
        host_u.access(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, e);
        host_u.access(1'b0, a, 8'h00);
        `CHK({reg_rvalid_o, hit_seen, reg_rdata_o}, {1'b1, (a >= 8'h5f && a <= 8'h64), e})
    endtask
    task start(input logic w, p);
        {window_start_i, period_start_i} = {w, p};
        cyc(1);
        {window_start_i, period_start_i} = 2'b00;
        cyc(1);
    endtask
    task t_reset;
        for (int i = 0; i < 6; i++) rd(8'h5f + 8'(i), rv[i]);
        rd(8'h70, 8'h00);
        `CHK({closed_window_cycles_o, open_window_cycles_o}, {24'h276, 24'h050})
        `CHK({window_err_count_down_step_o, window_err_count_up_step_o}, {5'h08, 5'h08})
        `CHK(heartbeat_period_cycles_o, 24'h2c6)
    endtask
    task t_window;
        wr(8'h5f, 8'h05);
        `CHK(closed_window_cycles_o, 24'h276)
        start(1'b1, 1'b0);
        `CHK({closed_window_cycles_o, open_window_cycles_o}, {24'h00a, 24'h028})
        wr(8'h5f, 8'h02);
        start(1'b1, 1'b0);
        `CHK({closed_window_cycles_o, open_window_cycles_o}, {24'h00a, 24'h028})
    endtask
    task t_steps;
        wr(8'h60, 8'hf0);
        wr(8'h61, 8'h0f);
        wr(8'h62, 8'h3c);
        wr(8'h63, 8'h7f);
        start(1'b0, 1'b1);
        `CHK({question_pass_down_step_o, question_pass_up_step_o}, {5'h01, 5'h10})
        `CHK({total_err_down_step_o, total_err_up_step_o}, {5'h04, 5'h0d})
        `CHK(heartbeat_period_cycles_o, 24'h4f6)
        start(1'b1, 1'b0);
        `CHK({window_err_count_down_step_o, window_err_count_up_step_o}, {5'h10, 5'h01})
        wr(8'h63, 8'h00);
        start(1'b0, 1'b1);
        `CHK(heartbeat_period_cycles_o, 24'h4f6)
    endtask
    task t_react;
        wr(8'h64, 8'h1c);
        {watchdog_error_i, window_error_i, lin_rx_only_cfg_i, can_rx_only_cfg_i} = 4'hc;
        cyc(2);
        `CHK({reset_request_o, lin_rx_only_o, can_rx_only_o, keep_question_o, question_period_o}, {4'hf, 9'h100})
        config_lock_i = 1;
        wr(8'h64, 8'h03);
        rd(8'h64, 8'h1c);
        config_lock_i = 0;
        wr(8'h64, 8'h03);
        cyc(2);
        `CHK({reset_request_o, lin_rx_only_o, can_rx_only_o, keep_question_o, question_period_o}, {4'h0, 9'h010})
    endtask
    task final_report;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000 n_errors++;
        final_report;
    end
    initial begin
        cyc(2);
        rst_i = 0;
        t_reset;
        t_window;
        t_steps;
        t_react;
        final_report;
    end
endmodule
`default_nettype wire
